// [rtl/t8wm_top.sv]
// 8-bit timer waveform generator (clear-on-match, fast and phase-correct PWM) with APB registers
//
// Notes on behaviour
// - Mode 2 clears counter when it equals compare A; compare A is TOP.
// - Clear-on-match compare writes act at once; missed match wraps via 0xFF.
// - Clear-on-match sets compare flag every time counter reaches TOP.
// - Clear-on-match with select 1 toggles output on every match.
// - Clear-on-match sets overflow flag on the MAX to zero step.
// - Modes 3 and 7 are fast PWM; TOP is 0xFF or compare A.
// - Fast PWM clears counter on the timer tick after TOP.
// - Fast PWM select 2 clears on match, sets at BOTTOM; 3 inverts.
// - Fast PWM sets overflow flag each time counter reaches TOP.
// - Fast PWM with TOP 0xFF repeats every 256 timer ticks.
// - Fast PWM compare BOTTOM gives spike; compare MAX gives constant level.
// - Fast PWM select 1 toggles on match in mode 7 only, compare still double buffered.
// - Modes 1 and 5 are phase-correct; TOP is 0xFF or compare A.
// - Phase-correct counter holds TOP one tick, then counts down.
// - Phase-correct select 2 clears on up match, sets on down; 3 inverts.
// - Phase-correct sets overflow flag each time counter reaches BOTTOM.
// - Phase-correct with TOP 0xFF repeats every 510 timer ticks.
// - Phase-correct compare BOTTOM holds low, MAX holds high; inverting opposite.
// - Phase-correct output is realigned at BOTTOM without a match.
// - Phase-correct compare at MAX gives the down-count match level.
// - Waveform reaches pin only while pin direction is output.
// - Compare buffered in PWM, loaded at TOP; direct in other modes.
// - Select 0 takes no action; pin stays under port control.
// - PWM select 2 and 3 match ignored when compare equals TOP; action done at TOP.
`timescale 1ns/1ns
`default_nettype none
module t8wm_top (
	input wire logic CLOCK,
	input wire logic ARST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	output logic WAVE_PIN_OUT,
	output logic WAVE_PIN_OE
);
	import t8wm_pkg::*;

	// Software-visible state
	logic [2:0] wave_mode_sel;
	logic [1:0] compare_output_sel_a;
	logic [2:0] clk_sel;
	logic [7:0] compare_buf;
	logic [7:0] compare_a_value;
	logic [7:0] counter_value;
	logic overflow_flag;
	logic compare_a_flag;
	logic port_level;
	logic port_dir;

	// Internal timer state
	logic count_down;
	logic wave_out_a;
	logic match_block;
	logic [9:0] pre_cnt;
	logic [9:0] pre_mask;

	// Next values
	logic [7:0] next_counter;
	logic next_down;
	logic next_wave;
	logic [7:0] next_compare;
	logic [31:0] next_rdata;

	// APB phase and address decode
	wire logic setup_ph = PSEL & ~PENABLE;
	wire logic access_ph = PSEL & PENABLE & PREADY;
	wire logic wr_en = access_ph & PWRITE;
	wire logic hit_ctrl = (PADDR == T8WM_OFS_CTRL);
	wire logic hit_cmp = (PADDR == T8WM_OFS_CMP);
	wire logic hit_cnt = (PADDR == T8WM_OFS_CNT);
	wire logic hit_flag = (PADDR == T8WM_OFS_FLAG);
	wire logic hit_pin = (PADDR == T8WM_OFS_PIN);
	wire logic mapped = hit_ctrl | hit_cmp | hit_cnt | hit_flag | hit_pin;
	wire logic cnt_wr = wr_en & hit_cnt;
	wire logic clr_ovf = wr_en & hit_flag & PWDATA[T8WM_FLAG_OVF];
	wire logic clr_cmp = wr_en & hit_flag & PWDATA[T8WM_FLAG_CMP];

	// Prescaler mask for the selected division
	always_comb begin
		unique case (clk_sel)
			T8WM_CLK_STOP: pre_mask = T8WM_PRE_MASK1;
			T8WM_CLK_DIV1: pre_mask = T8WM_PRE_MASK1;
			T8WM_CLK_DIV8: pre_mask = T8WM_PRE_MASK8;
			T8WM_CLK_DIV32: pre_mask = T8WM_PRE_MASK32;
			T8WM_CLK_DIV64: pre_mask = T8WM_PRE_MASK64;
			T8WM_CLK_DIV128: pre_mask = T8WM_PRE_MASK128;
			T8WM_CLK_DIV256: pre_mask = T8WM_PRE_MASK256;
			T8WM_CLK_DIV1024: pre_mask = T8WM_PRE_MASK1024;
		endcase
	end

	// Timer tick is a clock enable derived from the free-running prescaler
	wire logic tick = (clk_sel != T8WM_CLK_STOP) & ((pre_cnt & pre_mask) == pre_mask);

	// Mode decode
	wire logic is_ctc = (wave_mode_sel == T8WM_MODE_CTC);
	wire logic is_fast = (wave_mode_sel == T8WM_MODE_FAST_FF) | (wave_mode_sel == T8WM_MODE_FAST_OCR);
	wire logic is_pc = (wave_mode_sel == T8WM_MODE_PC_FF) | (wave_mode_sel == T8WM_MODE_PC_OCR);
	wire logic is_pwm = is_fast | is_pc;
	wire logic top_is_cmp = is_ctc | (wave_mode_sel == T8WM_MODE_FAST_OCR) |
		(wave_mode_sel == T8WM_MODE_PC_OCR);

	// Compare value in use: buffered in PWM, direct otherwise
	wire logic [7:0] cmp_val = is_pwm ? compare_a_value : compare_buf;
	wire logic [7:0] top_val = top_is_cmp ? cmp_val : T8WM_MAX;
	wire logic at_top = (counter_value == top_val);
	wire logic at_bottom = (counter_value == T8WM_BOTTOM);
	wire logic at_max = (counter_value == T8WM_MAX);
	wire logic cmp_is_top = (cmp_val == top_val);

	// Match is blocked for one tick after software writes the counter
	wire logic match = (counter_value == cmp_val) & ~match_block;

	// Flag events on the timer tick
	wire logic ovf_ev = tick & ~cnt_wr & (is_pc ? (count_down & at_bottom) :
		is_fast ? at_top : at_max);
	wire logic cmp_ev = tick & ~cnt_wr & match;

	// Toggle select only acts in the PWM modes whose TOP is compare A
	wire logic pwm_toggle = (compare_output_sel_a == T8WM_COM_TOGGLE) &
		((wave_mode_sel == T8WM_MODE_FAST_OCR) | (wave_mode_sel == T8WM_MODE_PC_OCR));
	wire logic com_hi = compare_output_sel_a[1];
	wire logic com_lo = compare_output_sel_a[0];

	// Counter sequence per mode
	always_comb begin
		next_counter = counter_value;
		next_down = is_pc & count_down;
		if (cnt_wr) begin
			next_counter = PWDATA[7:0];
		end else if (tick) begin
			if (is_pc) begin
				if (!count_down && at_top) begin
					// TOP has been held for this tick, now go down
					next_down = 1'b1;
					next_counter = counter_value - T8WM_ONE;
				end else if (count_down && at_bottom) begin
					next_down = 1'b0;
					next_counter = counter_value + T8WM_ONE;
				end else if (count_down) begin
					next_counter = counter_value - T8WM_ONE;
				end else begin
					next_counter = counter_value + T8WM_ONE;
				end
			end else if ((is_ctc || is_fast) && at_top) begin
				next_counter = T8WM_BOTTOM;
			end else begin
				// A TOP below the count is missed and the counter wraps
				next_counter = counter_value + T8WM_ONE;
			end
		end
	end

	// Compare register load: at TOP in PWM modes, mirrored otherwise
	always_comb begin
		next_compare = compare_a_value;
		if (!is_pwm) begin
			next_compare = compare_buf;
		end else if (tick && at_top && !count_down) begin
			next_compare = compare_buf;
		end
	end

	// Waveform register actions
	always_comb begin
		next_wave = wave_out_a;
		if (tick && !cnt_wr) begin
			if (is_fast) begin
				if (com_hi) begin
					if (match && !cmp_is_top) begin
						next_wave = com_lo;
					end
					if (at_top) begin
						// Level for the new period, seen from BOTTOM
						next_wave = ~com_lo;
					end
				end else if (pwm_toggle && match) begin
					next_wave = ~wave_out_a;
				end
			end else if (is_pc) begin
				if (com_hi) begin
					if (match && !cmp_is_top) begin
						next_wave = count_down ? ~com_lo : com_lo;
					end
					if (!count_down && at_top && cmp_is_top) begin
						next_wave = ~com_lo;
					end
					if (count_down && at_bottom) begin
						// Realign to the up-slope level for symmetry
						next_wave = (cmp_val != T8WM_BOTTOM) ^ com_lo;
					end
				end else if (pwm_toggle && match) begin
					next_wave = ~wave_out_a;
				end
			end else if (match) begin
				unique case (compare_output_sel_a)
					T8WM_COM_OFF: next_wave = wave_out_a;
					T8WM_COM_TOGGLE: next_wave = ~wave_out_a;
					T8WM_COM_CLEAR: next_wave = 1'b0;
					T8WM_COM_SET: next_wave = 1'b1;
				endcase
			end
		end
	end

	// Read data mux
	always_comb begin
		next_rdata = T8WM_RD_ZERO;
		if (hit_ctrl) begin
			next_rdata[T8WM_CTRL_MODE_LSB +: 3] = wave_mode_sel;
			next_rdata[T8WM_CTRL_COM_LSB +: 2] = compare_output_sel_a;
			next_rdata[T8WM_CTRL_CLK_LSB +: 3] = clk_sel;
		end else if (hit_cmp) begin
			next_rdata[7:0] = compare_buf;
		end else if (hit_cnt) begin
			next_rdata[7:0] = counter_value;
		end else if (hit_flag) begin
			next_rdata[T8WM_FLAG_OVF] = overflow_flag;
			next_rdata[T8WM_FLAG_CMP] = compare_a_flag;
		end else if (hit_pin) begin
			next_rdata[T8WM_PIN_LVL] = port_level;
			next_rdata[T8WM_PIN_DIR] = port_dir;
		end
	end

	// APB answer: one wait-free access phase after each setup
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			PREADY <= 1'b0;
			PRDATA <= T8WM_RD_ZERO;
			PSLVERR <= 1'b0;
		end else begin
			PREADY <= setup_ph;
			PRDATA <= (setup_ph & ~PWRITE) ? next_rdata : T8WM_RD_ZERO;
			PSLVERR <= setup_ph & ~mapped;
		end
	end

	// Control registers
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			wave_mode_sel <= T8WM_RST_MODE;
			compare_output_sel_a <= T8WM_RST_COM;
			clk_sel <= T8WM_RST_CLK;
		end else if (wr_en && hit_ctrl) begin
			wave_mode_sel <= PWDATA[T8WM_CTRL_MODE_LSB +: 3];
			compare_output_sel_a <= PWDATA[T8WM_CTRL_COM_LSB +: 2];
			clk_sel <= PWDATA[T8WM_CTRL_CLK_LSB +: 3];
		end
	end

	// Compare buffer and port bits
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			compare_buf <= T8WM_RST_BYTE;
			port_level <= 1'b0;
			port_dir <= 1'b0;
		end else begin
			if (wr_en && hit_cmp) begin
				compare_buf <= PWDATA[7:0];
			end
			if (wr_en && hit_pin) begin
				port_level <= PWDATA[T8WM_PIN_LVL];
				port_dir <= PWDATA[T8WM_PIN_DIR];
			end
		end
	end

	// Timer core
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			pre_cnt <= 10'h000;
			counter_value <= T8WM_RST_BYTE;
			count_down <= 1'b0;
			compare_a_value <= T8WM_RST_BYTE;
			wave_out_a <= 1'b0;
			match_block <= 1'b0;
		end else begin
			pre_cnt <= pre_cnt + T8WM_PRE_STEP;
			counter_value <= next_counter;
			count_down <= next_down;
			compare_a_value <= next_compare;
			wave_out_a <= next_wave;
			match_block <= cnt_wr | (match_block & ~tick);
		end
	end

	// Sticky flags: a set in the clear cycle wins
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			overflow_flag <= 1'b0;
			compare_a_flag <= 1'b0;
		end else begin
			overflow_flag <= ovf_ev | (overflow_flag & ~clr_ovf);
			compare_a_flag <= cmp_ev | (compare_a_flag & ~clr_cmp);
		end
	end

	// Pin: waveform overrides port level while a select is non-zero
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			WAVE_PIN_OUT <= 1'b0;
			WAVE_PIN_OE <= 1'b0;
		end else begin
			WAVE_PIN_OUT <= (compare_output_sel_a != T8WM_COM_OFF) ? wave_out_a : port_level;
			WAVE_PIN_OE <= port_dir;
		end
	end
endmodule : t8wm_top
`default_nettype wire

// [inc/t8wm_pkg.sv]
// Register map, field layout and mode codes of the 8-bit waveform timer
`default_nettype none
package t8wm_pkg;
	// Byte offsets on the APB slave
	localparam logic [7:0] T8WM_OFS_CTRL = 8'h00;
	localparam logic [7:0] T8WM_OFS_CMP = 8'h04;
	localparam logic [7:0] T8WM_OFS_CNT = 8'h08;
	localparam logic [7:0] T8WM_OFS_FLAG = 8'h0c;
	localparam logic [7:0] T8WM_OFS_PIN = 8'h10;

	// Field positions
	localparam int T8WM_CTRL_MODE_LSB = 0;
	localparam int T8WM_CTRL_COM_LSB = 4;
	localparam int T8WM_CTRL_CLK_LSB = 8;
	localparam int T8WM_FLAG_OVF = 0;
	localparam int T8WM_FLAG_CMP = 1;
	localparam int T8WM_PIN_LVL = 0;
	localparam int T8WM_PIN_DIR = 1;

	// Reset values
	localparam logic [2:0] T8WM_RST_MODE = 3'h0;
	localparam logic [1:0] T8WM_RST_COM = 2'h0;
	localparam logic [2:0] T8WM_RST_CLK = 3'h0;
	localparam logic [7:0] T8WM_RST_BYTE = 8'h00;
	localparam logic [31:0] T8WM_RD_ZERO = 32'h0000_0000;

	// Waveform mode codes
	localparam logic [2:0] T8WM_MODE_NORMAL = 3'h0;
	localparam logic [2:0] T8WM_MODE_PC_FF = 3'h1;
	localparam logic [2:0] T8WM_MODE_CTC = 3'h2;
	localparam logic [2:0] T8WM_MODE_FAST_FF = 3'h3;
	localparam logic [2:0] T8WM_MODE_PC_OCR = 3'h5;
	localparam logic [2:0] T8WM_MODE_FAST_OCR = 3'h7;

	// Compare output select codes
	localparam logic [1:0] T8WM_COM_OFF = 2'h0;
	localparam logic [1:0] T8WM_COM_TOGGLE = 2'h1;
	localparam logic [1:0] T8WM_COM_CLEAR = 2'h2;
	localparam logic [1:0] T8WM_COM_SET = 2'h3;

	// Counter extremes
	localparam logic [7:0] T8WM_BOTTOM = 8'h00;
	localparam logic [7:0] T8WM_MAX = 8'hff;
	localparam logic [7:0] T8WM_ONE = 8'h01;

	// Timer clock select codes and prescaler masks (N-1)
	localparam logic [2:0] T8WM_CLK_STOP = 3'h0;
	localparam logic [2:0] T8WM_CLK_DIV1 = 3'h1;
	localparam logic [2:0] T8WM_CLK_DIV8 = 3'h2;
	localparam logic [2:0] T8WM_CLK_DIV32 = 3'h3;
	localparam logic [2:0] T8WM_CLK_DIV64 = 3'h4;
	localparam logic [2:0] T8WM_CLK_DIV128 = 3'h5;
	localparam logic [2:0] T8WM_CLK_DIV256 = 3'h6;
	localparam logic [2:0] T8WM_CLK_DIV1024 = 3'h7;
	localparam logic [9:0] T8WM_PRE_MASK1 = 10'h000;
	localparam logic [9:0] T8WM_PRE_MASK8 = 10'h007;
	localparam logic [9:0] T8WM_PRE_MASK32 = 10'h01f;
	localparam logic [9:0] T8WM_PRE_MASK64 = 10'h03f;
	localparam logic [9:0] T8WM_PRE_MASK128 = 10'h07f;
	localparam logic [9:0] T8WM_PRE_MASK256 = 10'h0ff;
	localparam logic [9:0] T8WM_PRE_MASK1024 = 10'h3ff;
	localparam logic [9:0] T8WM_PRE_STEP = 10'h001;
endpackage : t8wm_pkg
`default_nettype wire

// [sim/t8wm_asserts.sv]
// Port-level checker for the 8-bit waveform timer
`timescale 1ns/1ns
`default_nettype none
module t8wm_asserts
	import t8wm_pkg::*;
(
	input wire logic CLOCK,
	input wire logic ARST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic WAVE_PIN_OUT,
	input wire logic WAVE_PIN_OE
);
	logic [2:0] mode;
	logic [1:0] com;
	logic [2:0] clk_sel;
	logic [7:0] cmp;
	logic lvl;
	logic [10:0] settle;
	logic [9:0] run;
	logic [9:0] rise_run;
	logic last_out;
	// Decode of completed writes and of steady running
	wire wr_done = PSEL && PENABLE && PREADY && PWRITE;
	wire pin_wr = wr_done && PADDR == T8WM_OFS_PIN;
	wire cfg_wr = wr_done && (PADDR == T8WM_OFS_CTRL || PADDR == T8WM_OFS_CMP);
	wire mapped = PADDR inside {T8WM_OFS_CTRL, T8WM_OFS_CMP, T8WM_OFS_CNT, T8WM_OFS_FLAG, T8WM_OFS_PIN};
	wire dir_bit = PWDATA[T8WM_PIN_DIR];
	wire steady = settle == 11'h7ff && clk_sel == T8WM_CLK_DIV1;
	wire extreme = cmp == T8WM_BOTTOM || cmp == T8WM_MAX;
	wire rise = WAVE_PIN_OUT && !last_out;
	// Mirror of settings; long gaps counted here since repetitions cannot reach them
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			mode <= T8WM_RST_MODE;
			com <= T8WM_RST_COM;
			clk_sel <= T8WM_RST_CLK;
			cmp <= T8WM_RST_BYTE;
			lvl <= 1'b0;
			settle <= 11'h000;
			run <= 10'h000;
			rise_run <= 10'h000;
			last_out <= 1'b0;
		end else begin
			if (wr_done && PADDR == T8WM_OFS_CTRL) begin
				mode <= PWDATA[2:0];
				com <= PWDATA[5:4];
				clk_sel <= PWDATA[10:8];
			end
			if (wr_done && PADDR == T8WM_OFS_CMP) cmp <= PWDATA[7:0];
			if (pin_wr) lvl <= PWDATA[T8WM_PIN_LVL];
			// Buffered compare needs up to two periods to show, hence the long settle
			settle <= cfg_wr ? 11'h000 : settle + {10'h000, settle != 11'h7ff};
			run <= (WAVE_PIN_OUT != last_out) ? 10'h000 : run + {9'h000, run != 10'h3ff};
			rise_run <= rise ? 10'h000 : rise_run + {9'h000, rise_run != 10'h3ff};
			last_out <= WAVE_PIN_OUT;
		end
	end
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (!ARST_N);
	ready_timing_a: assert property (PSEL && !PENABLE |=> PREADY)
		else $error("no ready after setup");
	ready_cause_a: assert property (PREADY |-> $past(PSEL) && !$past(PENABLE) ##1 !PREADY)
		else $error("ready without setup or too long");
	err_cause_a: assert property (PSLVERR |-> PREADY && !mapped)
		else $error("error on mapped or idle bus");
	unmapped_err_a: assert property (PREADY && !mapped |-> PSLVERR)
		else $error("unmapped access not refused");
	rdata_idle_a: assert property (!PREADY |-> PRDATA == T8WM_RD_ZERO)
		else $error("read data outside access");
	// Direction register lands on the access edge, the pin flop one edge later
	oe_dir_a: assert property (pin_wr |-> ##2 WAVE_PIN_OE == $past(dir_bit, 2))
		else $error("enable not direction bit");
	oe_hold_a: assert property (!$past(pin_wr) |=> $stable(WAVE_PIN_OE))
		else $error("enable moved without write");
	port_level_a: assert property (com == T8WM_COM_OFF && $past(com) == T8WM_COM_OFF && $stable(lvl) |-> WAVE_PIN_OUT == lvl)
		else $error("pin not under port control");
	flat_level_a: assert property (steady && com[1] && ((mode == T8WM_MODE_PC_FF && extreme)
		|| (mode == T8WM_MODE_FAST_FF && cmp == T8WM_MAX)) |-> WAVE_PIN_OUT == ((cmp != T8WM_BOTTOM) ^ com[0]))
		else $error("extreme compare level wrong");
	toggle_period_a: assert property (steady && com == T8WM_COM_TOGGLE
		&& (mode == T8WM_MODE_CTC || mode == T8WM_MODE_FAST_OCR) && WAVE_PIN_OUT != last_out |-> run == {2'h0, cmp})
		else $error("toggle spacing wrong");
	full_period_a: assert property (steady && com[1] && !extreme && rise
		&& (mode == T8WM_MODE_FAST_FF || mode == T8WM_MODE_PC_FF) |-> rise_run == (mode == T8WM_MODE_FAST_FF ? 10'h0ff : 10'h1fd))
		else $error("pwm period wrong");
endmodule : t8wm_asserts
bind t8wm_top t8wm_asserts i_chk (.CLOCK(CLOCK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
	.PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
	.WAVE_PIN_OUT(WAVE_PIN_OUT), .WAVE_PIN_OE(WAVE_PIN_OE));
`default_nettype wire

// [sim/t8wm_top_tb_top.sv]
// Self-checking bench for the 8-bit waveform timer
`timescale 1ns/1ns
`default_nettype none
module t8wm_top_tb_top;
	import t8wm_pkg::*;
	logic CLOCK, ARST_N, PSEL, PENABLE, PWRITE;
	logic [7:0] PADDR;
	logic [31:0] PWDATA, PRDATA;
	logic PREADY, PSLVERR, WAVE_PIN_OUT, WAVE_PIN_OE;
	logic [33:0] exp_q[$];
	logic [33:0] e;
	logic [7:0] c;
	logic [2:0] tm[10] = '{3'h2, 3'h7, 3'h3, 3'h3, 3'h1, 3'h1, 3'h1, 3'h1, 3'h3, 3'h5};
	logic [1:0] tc[10] = '{2'h1, 2'h1, 2'h2, 2'h3, 2'h2, 2'h3, 2'h2, 2'h3, 2'h2, 2'h2};
	int miscompares = 0;
	int num_checks = 0;
	t8wm_top i_dut (.CLOCK(CLOCK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
		.PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.WAVE_PIN_OUT(WAVE_PIN_OUT), .WAVE_PIN_OE(WAVE_PIN_OE));
	initial begin
		CLOCK = 1'b0;
		forever #5 CLOCK = ~CLOCK;
	end
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : end_of_test
	task automatic bad(input string m);
		miscompares++;
		$display("BAD %0t %s", $time, m);
	endtask : bad
	// Master holds the request until ready; the note is queued at setup
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] x);
		int n;
		@(posedge CLOCK);
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		exp_q.push_back({w, x});
		@(posedge CLOCK);
		PENABLE <= 1'b1;
		n = 0;
		do begin
			@(posedge CLOCK);
			n++;
		end while (PREADY !== 1'b1 && n < 16);
		if (n >= 16) begin
			bad("no ready");
			end_of_test();
		end
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] v);
		apb(1'b0, a, 32'h0, {1'b0, v});
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 33'h0);
	endtask : wr
	function automatic logic [31:0] cw(input logic [2:0] m, input logic [1:0] s);
		return {21'h0, T8WM_CLK_DIV1, 2'h0, s, 1'b0, m};
	endfunction : cw
	// Watcher: oldest note against each completed transfer
	always @(posedge CLOCK) begin
		if (ARST_N && PSEL && PENABLE && PREADY === 1'b1) begin
			e = exp_q.pop_front();
			num_checks++;
			if (PSLVERR !== e[32] || (!e[33] && PRDATA !== e[31:0])) bad("apb answer");
		end
	end
	initial begin
		repeat (100000) @(posedge CLOCK);
		bad("timeout");
		end_of_test();
	end
	initial begin
		{PSEL, PENABLE, PWRITE, PADDR, PWDATA} = 43'h0;
		ARST_N = 1'b0;
		c = 8'($urandom(57153));
		repeat (6) @(posedge CLOCK);
		ARST_N <= 1'b1;
		// Reset values, then holes past the map
		for (int a = 0; a <= 20; a += 4) apb(1'b0, 8'(a), 32'h0, {a == 20, 32'h0});
		apb(1'b1, 8'h18, 32'hffff_ffff, {1'b1, 32'h0});
		// Port control while no waveform is selected
		for (int i = 0; i < 4; i++) begin
			wr(T8WM_OFS_PIN, 32'(i));
			rd(T8WM_OFS_PIN, 32'(i));
			num_checks++;
			if (WAVE_PIN_OE !== i[1] || WAVE_PIN_OUT !== i[0]) bad("pin");
		end
		// Flags: compare only, then a counter load past TOP forces the wrap
		wr(T8WM_OFS_CMP, 32'h3);
		wr(T8WM_OFS_CTRL, cw(T8WM_MODE_CTC, T8WM_COM_OFF));
		repeat (50) @(posedge CLOCK);
		rd(T8WM_OFS_FLAG, 32'h2);
		wr(T8WM_OFS_FLAG, 32'h3);
		wr(T8WM_OFS_CNT, 32'h80);
		repeat (300) @(posedge CLOCK);
		rd(T8WM_OFS_FLAG, 32'h3);
		foreach (tm[k]) begin
			if (k == 2 || k == 4) begin
				wr(T8WM_OFS_FLAG, 32'h3);
				wr(T8WM_OFS_CTRL, cw(tm[k], T8WM_COM_OFF));
				repeat (600) @(posedge CLOCK);
				rd(T8WM_OFS_FLAG, 32'h3);
			end
		end
		// Waveform table; the checker judges levels and periods
		foreach (tm[k]) begin
			c = 8'($urandom_range(254, 1));
			if (k == 6) c = T8WM_BOTTOM;
			if (k == 7 || k == 8) c = T8WM_MAX;
			wr(T8WM_OFS_CMP, {24'h0, c});
			wr(T8WM_OFS_CTRL, cw(tm[k], tc[k]));
			rd(T8WM_OFS_CTRL, cw(tm[k], tc[k]));
			rd(T8WM_OFS_CMP, {24'h0, c});
			repeat (2800) @(posedge CLOCK);
		end
		// Set then clear on match in clear-on-match mode, timer on the divide-by-8 tick
		wr(T8WM_OFS_CMP, 32'h5);
		wr(T8WM_OFS_CNT, 32'h0);
		for (int s = 3; s >= 2; s--) begin
			wr(T8WM_OFS_CTRL, {21'h0, T8WM_CLK_DIV8, 2'h0, 2'(s), 1'b0, T8WM_MODE_CTC});
			repeat (120) @(posedge CLOCK);
			num_checks++;
			if (WAVE_PIN_OUT !== s[0]) bad("set or clear on match");
		end
		end_of_test();
	end
endmodule : t8wm_top_tb_top
`default_nettype wire
